/* File: serial_io_shift_bus_tb.sv */
// Testbench: master and a two-slot chain of 4 and 8 bits, with checker.
// Assumes the FIFO of 8 nibbles inside the master.
`timescale 1ns/100ps
module serial_io_shift_bus_tb;
    import sio_pkg::*;
    typedef struct {
        sio_cycle_t  k;
        logic [11:0] din, dout, exp;
        logic        stl;
    } sio_row_t;
    sio_row_t rows [3] = '{
        '{SIO_CYC_NORMAL,    12'ha5c, 12'h3c9, 12'h3c9, 1'b0},
        '{SIO_CYC_IRQ_TIMED, 12'h5a3, 12'h0f0, 12'h3c9, 1'b0},
        '{SIO_CYC_IRQ_EVENT, 12'h1e7, 12'h0f0, 12'h3c9, 1'b1}};
    logic clk_i = 0, nrst_i = 0, req_i = 0, out_wr_i = 0, out_wr_irq_i = 0;
    logic out_wr_bit_i = 0, img_rd_irq_i = 0, nib_ready_i = 0, fault_clr_i = 0;
    logic [9:0] out_wr_addr_i = '0, img_rd_addr_i = '0;
    logic [9:0] analog_bits_i = 10'h080;
    logic [5:0] slot_cnt_i = 6'h02;
    // Position 0 holds 4 data bits, position 1 holds 8.
    logic [MAX_SLOTS-1:0][6:0] slot_bits_i = 224'h404;
    logic [11:0] in_bits_i = '0, out_bits_o, v;
    sio_variant_t variant_i = SIO_VAR_SMALL;
    sio_cycle_t cyc_kind_i = SIO_CYC_NORMAL;
    logic req_ready_o, done_o, refused_o, img_rd_data_o, nib_valid_o, st, rf;
    logic stop_o, io_not_ready_flag_o, bus_fault_o, irq_out_pending_o;
    logic [4:0] nib_data_o, got[$], exq[$];
    logic [7:0] interrupt_stack_status_o;
    int bad_count = 0, n_checks = 0;

    sio_bus_if bus ();
    sio_master i_sio_master (.clk_i, .nrst_i, .bus(bus), .variant_i,
        .slot_cnt_i, .slot_bits_i, .analog_bits_i, .req_i, .cyc_kind_i,
        .req_ready_o, .done_o, .refused_o, .out_wr_i, .out_wr_irq_i,
        .out_wr_addr_i, .out_wr_bit_i, .img_rd_addr_i, .img_rd_irq_i,
        .img_rd_data_o, .nib_valid_o, .nib_ready_i, .nib_data_o, .stop_o,
        .io_not_ready_flag_o, .interrupt_stack_status_o, .bus_fault_o,
        .fault_clr_i, .irq_out_pending_o);
    sio_chain i_sio_chain (.clk_i, .nrst_i, .bus(bus), .in_bits_i,
        .out_bits_o);
    sio_shift_chk #(.NBITS(14)) i_sio_shift_chk (.clk_i, .nrst_i,
        .sclk(bus.sclk), .to_chain(bus.to_chain), .from_chain(bus.from_chain),
        .load(bus.load), .apply(bus.apply));

    always #50 clk_i = ~clk_i;
    always @(posedge clk_i)
        if (nib_valid_o && nib_ready_i)
            got.push_back(nib_data_o);

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("unexpected at %0t: seen %h wanted %h", $time, s, e);
        end
    endtask : check

    task automatic wr_img(input logic irq, input logic [11:0] d);
        for (int i = 0; i < 12; i++)
        begin
            @(posedge clk_i);
            {out_wr_i, out_wr_irq_i, out_wr_addr_i} <= {1'b1, irq, 10'(i)};
            out_wr_bit_i <= d[i];
        end
        @(posedge clk_i);
        out_wr_i <= 1'b0;
        @(negedge clk_i);
    endtask : wr_img

    task automatic rd_img(input logic irq);
        for (int i = 0; i < 12; i++)
        begin
            @(posedge clk_i);
            {img_rd_irq_i, img_rd_addr_i} <= {irq, 10'(i)};
            @(posedge clk_i);
            @(negedge clk_i);
            v[i] = img_rd_data_o;
        end
    endtask : rd_img

    // Waits for done; a cycle still busy after 4000 cycles is stalled
    // on the full FIFO, which is then drained.
    task automatic run(input sio_cycle_t k);
        int n;
        st = 1'b0;
        @(posedge clk_i);
        {req_i, cyc_kind_i} <= {1'b1, k};
        @(posedge clk_i);
        req_i <= 1'b0;
        for (n = 0; n < 9000; n++)
        begin
            @(negedge clk_i);
            if (done_o)
                break;
            if (n == 4000)
            begin
                st = 1'b1;
                @(posedge clk_i);
                nib_ready_i <= 1'b1;
            end
        end
        rf = refused_o;
        if (n == 9000)
        begin
            bad_count++;
            give_verdict();
        end
    endtask : run

    initial
    begin
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(negedge clk_i);
        check({stop_o, req_ready_o, bus_fault_o}, 3'b010);
        foreach (rows[r])
        begin
            @(posedge clk_i);
            in_bits_i <= rows[r].din;
            wr_img(1'b0, rows[r].dout);
            run(rows[r].k);
            check({st, rf}, {rows[r].stl, 1'b0});
            check(out_bits_o, rows[r].exp);
            rd_img(rows[r].k != SIO_CYC_NORMAL);
            check(v, rows[r].din);
            check(bus_fault_o, 1'b0);
            for (int j = 2; j >= 0; j--)
                exq.push_back({rows[r].k != SIO_CYC_NORMAL,
                               rows[r].din[j*4+:4]});
            $display("row %0d done", r);
        end
        repeat (4) @(negedge clk_i);
        check(got.size(), 9);
        foreach (exq[j])
            check(got[j], exq[j]);
        run(SIO_CYC_IRQ_OUT);
        check({rf, out_bits_o}, {1'b0, 12'h3c9});
        wr_img(1'b1, 12'h6b2);
        check(irq_out_pending_o, 1'b1);
        run(SIO_CYC_IRQ_OUT);
        check({irq_out_pending_o, out_bits_o}, 12'h6b2);
        run(SIO_CYC_NORMAL);
        check(out_bits_o, 12'h6b2);
        $display("interrupt output test done");
        // Slot 1 shortened to four bits puts a zero where a check is due.
        @(posedge clk_i);
        {in_bits_i, slot_bits_i[1]} <= {12'h000, 7'h04};
        run(SIO_CYC_IRQ_TIMED);
        check(bus_fault_o, 1'b1);
        @(posedge clk_i);
        fault_clr_i <= 1'b1;
        @(posedge clk_i);
        fault_clr_i <= 1'b0;
        @(negedge clk_i);
        check(bus_fault_o, 1'b0);
        @(posedge clk_i);
        {analog_bits_i, slot_bits_i[1]} <= {10'h090, 7'h08};
        run(SIO_CYC_NORMAL);
        check({rf, stop_o, io_not_ready_flag_o}, 3'b111);
        check(interrupt_stack_status_o, STACK_IONR_MASK);
        @(posedge clk_i);
        nrst_i <= 1'b0;
        {analog_bits_i, slot_cnt_i} <= {10'h0, 6'h04};
        slot_bits_i[3:2] <= {7'h76, 7'h7f};
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(negedge clk_i);
        check({stop_o, interrupt_stack_status_o, req_ready_o}, 10'h001);
        run(SIO_CYC_NORMAL);
        check({rf, stop_o}, 2'b11);
        $display("limit and reset tests done");
        give_verdict();
    end
endmodule : serial_io_shift_bus_tb

/* File: sio_bus_if.sv */
// Wires of the serial I/O shift bus between the master and the chain.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface sio_bus_if;
    logic sclk;
    logic to_chain;
    logic from_chain;
    logic load;
    logic apply;

    modport master (output sclk, output to_chain, output load,
                    output apply, input from_chain);
    modport chain  (input sclk, input to_chain, input load,
                    input apply, output from_chain);
endinterface : sio_bus_if

/* File: sio_chain.sv */
// Daisy chain of slot shift registers, one segment per chain position.
// Assumes the master's sclk, load and apply are synchronous levels.
`timescale 1ns/100ps
module sio_chain
    import sio_pkg::*;
#(
    parameter int unsigned NSLOT         = 2,
    // Per-position data widths, multiples of four, at least four.
    parameter int unsigned SLOT_W [NSLOT] = '{4, 8}
) (
    input  wire logic               clk_i,
    input  wire logic               nrst_i,
    sio_bus_if.chain                bus,
    input  wire logic [sum_w()-1:0] in_bits_i,
    output logic [sum_w()-1:0]      out_bits_o
);
    import sio_pkg::*;

    function automatic int unsigned sum_w();
        sum_w = 0;
        for (int k = 0; k < NSLOT; k++)
        begin
            sum_w = sum_w + SLOT_W[k];
        end
    endfunction : sum_w

    localparam int unsigned TOT = sum_w();
    localparam int unsigned LEN = TOT + NSLOT;

    logic [LEN-1:0] sh_r, sh_nxt, load_val;
    logic [TOT-1:0] out_r, out_nxt, unload;
    logic           sclk_d_r;

    // Slot k holds its data above its offset and its check bit on top.
    always_comb
    begin
        int unsigned off;
        int unsigned st;
        off      = 0;
        st       = 0;
        load_val = '0;
        unload   = '0;
        for (int k = 0; k < NSLOT; k++)
        begin
            st = off + k;
            for (int b = 0; b < SLOT_W[k]; b++)
            begin
                load_val[st + b] = in_bits_i[off + b];
                unload[off + b]  = sh_r[st + b];
            end
            load_val[st + SLOT_W[k]] = CHECK_VAL;
            off = off + SLOT_W[k];
        end
    end

    always_comb
    begin
        sh_nxt  = sh_r;
        out_nxt = out_r;
        if (bus.load)
        begin
            sh_nxt = load_val;
        end
        else if (bus.sclk && !sclk_d_r)
        begin
            sh_nxt = {sh_r[LEN-2:0], bus.to_chain};
        end
        if (bus.apply)
        begin
            out_nxt = unload;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sh_r     <= '0;
            out_r    <= '0;
            sclk_d_r <= 1'b0;
        end
        else
        begin
            sh_r     <= sh_nxt;
            out_r    <= out_nxt;
            sclk_d_r <= bus.sclk;
        end
    end

    assign bus.from_chain = sh_r[LEN-1];
    assign out_bits_o     = out_r;
endmodule : sio_chain

/* File: sio_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; full and empty are exact.
`timescale 1ns/100ps
module sio_fifo #(
    parameter int unsigned WIDTH = 5,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]      cnt_r, cnt_nxt;
    logic             push, pop;

    assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o  = mem[rp_r];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb
    begin
        wp_nxt  = wp_r;
        rp_nxt  = rp_r;
        cnt_nxt = cnt_r;
        if (push)
        begin
            wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
        end
        if (pop)
        begin
            rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
        end
        if (push && !pop)
        begin
            cnt_nxt = cnt_r + (AW+1)'(1);
        end
        else if (pop && !push)
        begin
            cnt_nxt = cnt_r - (AW+1)'(1);
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end
        else
        begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem[wp_r] <= in_data_i;
        end
    end
endmodule : sio_fifo

/* File: sio_master.sv */
// Bus master of the serial I/O shift chain, with the image tables.
// Assumes the chain end sees sclk, load and apply as synchronous levels.
// Contract
// - Each slot carries four data bits plus check; here each slot carries slot_bits_i data bits plus check.
// - Wider modules bring their own shift register.
// - Normal cycle exchanges input and output images.
// - Interrupt variant runs interrupt input cycles.
// - Timed captures all, event captures slots 0,1.
// - Interrupt output cycle only after image written.
// - Interrupt output cycle also updates output image.
// - Chain length sums data bits, excludes checks.
// - Each data bit lasts 25 microseconds; a full FIFO holds the next cell at its start until it has room.
// - Module types contribute fixed bit counts.
// - Analog modules give 16 bits per channel.
// - Total chain length limited per variant.
// - Analog bits limited per variant.
// - Overlength stops and sets not-ready flag.
// - Modules located by position, no address.
// - Every exchange walks the whole chain.
`timescale 1ns/100ps
module sio_master
    import sio_pkg::*;
#(
    parameter bit IRQ_EN = 1'b1
) (
    input  wire logic                         clk_i,
    input  wire logic                         nrst_i,
    sio_bus_if.master                         bus,
    input  wire sio_pkg::sio_variant_t        variant_i,
    input  wire logic [5:0]                   slot_cnt_i,
    input  wire logic [sio_pkg::MAX_SLOTS-1:0][6:0] slot_bits_i,
    input  wire logic [9:0]                   analog_bits_i,
    input  wire logic                         req_i,
    input  wire sio_pkg::sio_cycle_t          cyc_kind_i,
    output logic                              req_ready_o,
    output logic                              done_o,
    output logic                              refused_o,
    input  wire logic                         out_wr_i,
    input  wire logic                         out_wr_irq_i,
    input  wire logic [9:0]                   out_wr_addr_i,
    input  wire logic                         out_wr_bit_i,
    input  wire logic [9:0]                   img_rd_addr_i,
    input  wire logic                         img_rd_irq_i,
    output logic                              img_rd_data_o,
    output logic                              nib_valid_o,
    input  wire logic                         nib_ready_i,
    output logic [4:0]                        nib_data_o,
    output logic                              stop_o,
    output logic                              io_not_ready_flag_o,
    output logic [7:0]                        interrupt_stack_status_o,
    output logic                              bus_fault_o,
    input  wire logic                         fault_clr_i,
    output logic                              irq_out_pending_o
);
    import sio_pkg::*;

    localparam logic [7:0] TMR_LAST = 8'(BIT_CYCLES - 1);
    localparam logic [7:0] TMR_HALF = 8'(HALF_CYCLES);

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_LOAD  = 5'h02,
        ST_SHIFT = 5'h04,
        ST_APPLY = 5'h08,
        ST_DONE  = 5'h10
    } sio_state_t;

    logic in_img     [MAX_CHAIN_BITS];
    logic irq_in_img [MAX_CHAIN_BITS];
    logic out_img    [MAX_CHAIN_BITS];
    logic irq_out_img[MAX_CHAIN_BITS];

    sio_state_t  state_r, state_nxt;
    sio_cycle_t  kind_r, kind_nxt;
    logic [7:0]  tmr_r, tmr_nxt;
    logic [4:0]  slot_r, slot_nxt;
    logic [6:0]  bit_r, bit_nxt;
    logic        chk_r, chk_nxt;
    logic [9:0]  base_r, base_nxt;
    logic [3:0]  nib_r, nib_nxt;
    logic [1:0]  ncnt_r, ncnt_nxt;
    logic        sclk_r, sclk_nxt;
    logic        sdo_r, sdo_nxt;
    logic        stop_r, stop_nxt;
    logic        fault_r, fault_nxt;
    logic        pend_r, pend_nxt;
    logic        refused_r, refused_nxt;
    logic        rd_r;
    logic [11:0] total_len;
    logic [9:0]  idx;
    logic        samp, cap, push, fifo_rdy, over, img_bit;

    // Chain length counts data bits only; check bits are walked extra.
    always_comb
    begin
        total_len = 12'h000;
        for (int i = 0; i < MAX_SLOTS; i++)
        begin
            if (i < int'(slot_cnt_i))
            begin
                total_len = total_len + {5'h00, slot_bits_i[i]};
            end
        end
    end

    assign over = (total_len > sio_max_len(variant_i))
               || ({2'h0, analog_bits_i} > sio_max_ana(variant_i));

    assign idx     = base_r + {3'h0, bit_r};
    assign img_bit = (kind_r == SIO_CYC_IRQ_OUT) ? irq_out_img[idx]
                                                 : out_img[idx];
    assign samp = (state_r == ST_SHIFT) && (tmr_r == TMR_HALF);
    assign cap  = (kind_r == SIO_CYC_NORMAL) || (kind_r == SIO_CYC_IRQ_TIMED)
               || ((kind_r == SIO_CYC_IRQ_EVENT)
                   && (slot_r < 5'(IRQ_SLOTS)));
    assign push = samp && !chk_r && cap && (ncnt_r == 2'h3);

    always_comb
    begin
        state_nxt   = state_r;
        kind_nxt    = kind_r;
        tmr_nxt     = tmr_r;
        slot_nxt    = slot_r;
        bit_nxt     = bit_r;
        chk_nxt     = chk_r;
        base_nxt    = base_r;
        nib_nxt     = nib_r;
        ncnt_nxt    = ncnt_r;
        sdo_nxt     = sdo_r;
        stop_nxt    = stop_r;
        pend_nxt    = pend_r;
        refused_nxt = refused_r;
        fault_nxt   = fault_r && !fault_clr_i;
        unique case (state_r)
            ST_IDLE:
            begin
                if (req_i)
                begin
                    state_nxt = ST_DONE;
                    if (stop_r || (slot_cnt_i == 6'h00)
                        || (!IRQ_EN && (cyc_kind_i != SIO_CYC_NORMAL)))
                    begin
                        refused_nxt = 1'b1;
                    end
                    else if (over)
                    begin
                        stop_nxt    = 1'b1;
                        refused_nxt = 1'b1;
                    end
                    else if ((cyc_kind_i != SIO_CYC_IRQ_OUT) || pend_r)
                    begin
                        state_nxt = ST_LOAD;
                        kind_nxt  = cyc_kind_i;
                    end
                end
            end
            ST_LOAD:
            begin
                // Start at the far end of the chain, its check bit first.
                state_nxt = ST_SHIFT;
                tmr_nxt   = 8'h00;
                slot_nxt  = 5'(slot_cnt_i - 6'h01);
                chk_nxt   = 1'b1;
                bit_nxt   = 7'(slot_bits_i[slot_nxt] - 7'h01);
                base_nxt  = 10'(total_len - {5'h00, slot_bits_i[slot_nxt]});
                ncnt_nxt  = 2'h0;
                if (kind_r == SIO_CYC_IRQ_OUT)
                begin
                    pend_nxt = 1'b0;
                end
            end
            ST_SHIFT:
            begin
                if (tmr_r == 8'h00)
                begin
                    sdo_nxt = chk_r ? CHECK_VAL : img_bit;
                end
                if ((tmr_r == 8'h00) && !fifo_rdy)
                begin
                    tmr_nxt = tmr_r;
                end
                else if (tmr_r == TMR_LAST)
                begin
                    tmr_nxt = 8'h00;
                    if (chk_r)
                    begin
                        chk_nxt = 1'b0;
                    end
                    else if (bit_r != 7'h00)
                    begin
                        bit_nxt = bit_r - 7'h01;
                    end
                    else if (slot_r != 5'h00)
                    begin
                        slot_nxt = slot_r - 5'h01;
                        chk_nxt  = 1'b1;
                        bit_nxt  = 7'(slot_bits_i[slot_nxt] - 7'h01);
                        base_nxt = base_r - {3'h0, slot_bits_i[slot_nxt]};
                    end
                    else
                    begin
                        state_nxt = ((kind_r == SIO_CYC_NORMAL)
                                  || (kind_r == SIO_CYC_IRQ_OUT))
                                  ? ST_APPLY : ST_DONE;
                    end
                end
                else
                begin
                    tmr_nxt = tmr_r + 8'h01;
                end
                if (samp && chk_r && (bus.from_chain != CHECK_VAL))
                begin
                    fault_nxt = 1'b1;
                end
                if (samp && !chk_r && cap)
                begin
                    nib_nxt  = {nib_r[2:0], bus.from_chain};
                    ncnt_nxt = ncnt_r + 2'h1;
                end
            end
            ST_APPLY:
            begin
                state_nxt = ST_DONE;
            end
            ST_DONE:
            begin
                state_nxt   = ST_IDLE;
                refused_nxt = 1'b0;
            end
        endcase
        sclk_nxt = (state_nxt == ST_SHIFT) && (tmr_nxt > TMR_HALF);
        if (out_wr_i && out_wr_irq_i)
        begin
            pend_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_r   <= ST_IDLE;
            kind_r    <= SIO_CYC_NORMAL;
            tmr_r     <= 8'h00;
            slot_r    <= 5'h00;
            bit_r     <= 7'h00;
            chk_r     <= 1'b0;
            base_r    <= 10'h000;
            nib_r     <= 4'h0;
            ncnt_r    <= 2'h0;
            sclk_r    <= 1'b0;
            sdo_r     <= 1'b0;
            stop_r    <= 1'b0;
            fault_r   <= 1'b0;
            pend_r    <= 1'b0;
            refused_r <= 1'b0;
        end
        else
        begin
            state_r   <= state_nxt;
            kind_r    <= kind_nxt;
            tmr_r     <= tmr_nxt;
            slot_r    <= slot_nxt;
            bit_r     <= bit_nxt;
            chk_r     <= chk_nxt;
            base_r    <= base_nxt;
            nib_r     <= nib_nxt;
            ncnt_r    <= ncnt_nxt;
            sclk_r    <= sclk_nxt;
            sdo_r     <= sdo_nxt;
            stop_r    <= stop_nxt;
            fault_r   <= fault_nxt;
            pend_r    <= pend_nxt;
            refused_r <= refused_nxt;
        end
    end

    // Image tables; a cycle copy wins over a user write to the same bit.
    always_ff @(posedge clk_i)
    begin
        if (out_wr_i && (out_wr_addr_i < 10'(MAX_CHAIN_BITS)))
        begin
            if (out_wr_irq_i)
            begin
                irq_out_img[out_wr_addr_i] <= out_wr_bit_i;
            end
            else
            begin
                out_img[out_wr_addr_i] <= out_wr_bit_i;
            end
        end
        if (samp && !chk_r)
        begin
            unique case (kind_r)
                SIO_CYC_NORMAL:    in_img[idx] <= bus.from_chain;
                SIO_CYC_IRQ_TIMED: irq_in_img[idx] <= bus.from_chain;
                SIO_CYC_IRQ_EVENT:
                begin
                    if (cap)
                    begin
                        irq_in_img[idx] <= bus.from_chain;
                    end
                end
                SIO_CYC_IRQ_OUT:   out_img[idx] <= irq_out_img[idx];
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rd_r <= 1'b0;
        end
        else if (img_rd_addr_i < 10'(MAX_CHAIN_BITS))
        begin
            rd_r <= img_rd_irq_i ? irq_in_img[img_rd_addr_i]
                                 : in_img[img_rd_addr_i];
        end
        else
        begin
            rd_r <= 1'b0;
        end
    end

    sio_fifo #(
        .WIDTH (5),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .nrst_i      (nrst_i),
        .in_valid_i  (push),
        .in_ready_o  (fifo_rdy),
        .in_data_i   ({kind_r != SIO_CYC_NORMAL, nib_r[2:0], bus.from_chain}),
        .out_valid_o (nib_valid_o),
        .out_ready_i (nib_ready_i),
        .out_data_o  (nib_data_o)
    );

    assign bus.sclk                 = sclk_r;
    assign bus.to_chain             = sdo_r;
    assign bus.load                 = (state_r == ST_LOAD);
    assign bus.apply                = (state_r == ST_APPLY);
    assign req_ready_o              = (state_r == ST_IDLE);
    assign done_o                   = (state_r == ST_DONE);
    assign refused_o                = refused_r;
    assign img_rd_data_o            = rd_r;
    assign stop_o                   = stop_r;
    assign io_not_ready_flag_o      = stop_r;
    assign interrupt_stack_status_o = stop_r ? STACK_IONR_MASK : 8'h00;
    assign bus_fault_o              = fault_r;
    assign irq_out_pending_o        = pend_r;
endmodule : sio_master

/* File: sio_pkg.sv */
// Constants and types shared by the serial I/O shift bus ends.
// Assumes a 10 MHz system clock common to both ends.
package sio_pkg;

    localparam int unsigned CLK_PERIOD_NS  = 100;
    localparam int unsigned BIT_TIME_NS    = 25000;
    localparam int unsigned BIT_CYCLES     =
        (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HALF_CYCLES    = BIT_CYCLES / 2;

    localparam int unsigned SLOT_DATA_BITS = 4;
    localparam logic        CHECK_VAL      = 1'b1;
    localparam int unsigned MAX_SLOTS      = 32;
    localparam int unsigned IRQ_SLOTS      = 2;
    localparam int unsigned MAX_CHAIN_BITS = 704;

    localparam logic [11:0] LEN_SMALL      = 12'h100;
    localparam logic [11:0] LEN_MID        = 12'h1e0;
    localparam logic [11:0] LEN_LARGE      = 12'h2c0;
    localparam logic [11:0] ANA_SMALL      = 12'h080;
    localparam logic [11:0] ANA_MID        = 12'h100;
    localparam logic [11:0] ANA_LARGE      = 12'h200;

    localparam logic [7:0]  STACK_IONR_MASK = 8'h08;
    localparam int unsigned NIB_BITS       = 4;
    localparam int unsigned FIFO_DEPTH     = 8;

    typedef enum logic [1:0] {
        SIO_VAR_SMALL = 2'h0,
        SIO_VAR_MID   = 2'h1,
        SIO_VAR_LARGE = 2'h2
    } sio_variant_t;

    typedef enum logic [1:0] {
        SIO_CYC_NORMAL    = 2'h0,
        SIO_CYC_IRQ_TIMED = 2'h1,
        SIO_CYC_IRQ_EVENT = 2'h2,
        SIO_CYC_IRQ_OUT   = 2'h3
    } sio_cycle_t;

    function automatic logic [11:0] sio_max_len(input sio_variant_t v);
        unique case (v)
            SIO_VAR_SMALL: sio_max_len = LEN_SMALL;
            SIO_VAR_MID:   sio_max_len = LEN_MID;
            default:       sio_max_len = LEN_LARGE;
        endcase
    endfunction : sio_max_len

    function automatic logic [11:0] sio_max_ana(input sio_variant_t v);
        unique case (v)
            SIO_VAR_SMALL: sio_max_ana = ANA_SMALL;
            SIO_VAR_MID:   sio_max_ana = ANA_MID;
            default:       sio_max_ana = ANA_LARGE;
        endcase
    endfunction : sio_max_ana

endpackage : sio_pkg

/* File: sio_shift_chk.sv */
// Checker for the shift bus wires between the master and the chain.
// Assumes one clock and a chain of NBITS wire bits, checks included.
`timescale 1ns/100ps
module sio_shift_chk #(
    parameter int unsigned NBITS = 14
) (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic sclk,
    input  wire logic to_chain,
    input  wire logic from_chain,
    input  wire logic load,
    input  wire logic apply
);
    logic [15:0] gap_r, gap_nxt;
    logic [9:0]  rises_r, rises_nxt;
    logic        seen_r, seen_nxt, sclk_r, rise;

    always_comb
    begin
        rise      = sclk && !sclk_r;
        gap_nxt   = rise ? 16'h0 : gap_r + 16'h1;
        rises_nxt = load ? 10'h0 : rises_r + 10'(rise);
        seen_nxt  = !load && (seen_r || rise);
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            {gap_r, rises_r, seen_r, sclk_r} <= '0;
        end
        else
        begin
            {gap_r, rises_r, seen_r, sclk_r} <=
                {gap_nxt, rises_nxt, seen_nxt, sclk};
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence quiet_s;
        (!sclk) [*8];
    endsequence
    sequence first_rise_s;
        ##[110:125] $rose(sclk);
    endsequence

    load_pulse_a: assert property (load |=> !load)
        else $error("load strobe wider than one cycle");
    apply_pulse_a: assert property (apply |=> !apply)
        else $error("apply strobe wider than one cycle");
    strobe_excl_a: assert property (load |-> !apply && !sclk)
        else $error("load overlaps apply or shift clock");
    first_bit_a: assert property (load |=> quiet_s ##1 first_rise_s)
        else $error("first shift clock out of place");
    bit_time_a: assert property ($rose(sclk) && seen_r |-> gap_r >= 16'd249)
        else $error("bit cell shorter than 250 cycles");
    chain_len_a: assert property (apply |-> rises_r == 10'(NBITS))
        else $error("wrong number of shifted bits");
    data_hold_a: assert property (sclk && $past(sclk) |-> $stable(to_chain))
        else $error("serial data moved while clock high");
    from_hold_a: assert property ($changed(from_chain) |-> $past(sclk) || $past(load))
        else $error("returned data moved without shift or load");
endmodule : sio_shift_chk
